// ---- common/isr_defs.vh ----
// constants for the instrument status reporting block
// Contract
// RULE1: operation summary (status bit 7) is OR of enabled operation event bits.
// RULE2: falling filter latches 1-to-0 changes, rising filter latches 0-to-1 changes.
// RULE3: both filters set latch any change; both clear latch nothing.
// RULE4: questionable event register is read-only, latches filtered events, clears on read.
// RULE5: questionable bits: 11,10,9,5,4,3,2,1,0 as protection, unregulated, inhibit, limits, faults.
// RULE6: questionable condition read returns the live unlatched status.
// RULE7: questionable summary (status bit 3) is OR of enabled questionable event bits.
// RULE8: questionable filters gate latching per bit exactly like the operation group.
// RULE9: clear-status clears standard, operation, questionable events, status byte, error queue.
// RULE10: clear-status right after a terminator also empties output queue and message-available.
// RULE11: event summary (bit 5) is OR of enabled standard events; mask reads back.
// RULE12: standard events: power-on 7, command 5, execution 4, device 3, query 2, complete 0.
// RULE13: reading the standard event register returns it and then clears it.
// RULE14: operation-complete command sets bit 0 once all earlier pending work finishes.
// RULE15: parallel operations run on; operation-complete command does not block later commands.
// RULE16: operation-complete query queues ASCII one when pending work ends, without stalling.
// RULE17: master summary is OR of status bits enabled by service mask; zero mask blocks requests.
// RULE18: serial poll returns status byte with request-for-service in bit 6, then clears it.
// RULE19: status byte query shows master summary in bit 6 and clears nothing.
// RULE20: message-available clears at power-on, on clear-status, or when output queue empties. Code clears it on clear-status only after a terminator.
// RULE21: status byte: bits 7,6,5,4,3,2 are operation, master, event, message, questionable, error.
// RULE22: after wait, no commands run until pending work ends; only device clear aborts. Code still accepts the poll command during wait.
// RULE23: operation bits: constant voltage 0, constant current 1, off 2, waits 3 and 4.
// RULE24: requesting service asserts the request line and latches request-for-service until polled.
// RULE25: message-available is set whenever the output queue holds any byte.
// RULE26: a filtered event arriving with a clearing read keeps its event bit set.
`ifndef ISR_DEFS_VH
`define ISR_DEFS_VH

// status byte bit positions
`define ISR_STB_OPERATION_SUMMARY 7
`define ISR_STB_MSS 6
`define ISR_STB_ESB 5
`define ISR_STB_MAV 4
`define ISR_STB_QUESTIONABLE_SUMMARY 3
`define ISR_STB_ERR 2

// standard event bit positions
`define ISR_ESR_PON 7
`define ISR_ESR_CME 5
`define ISR_ESR_EXE 4
`define ISR_ESR_DDE 3
`define ISR_ESR_QYE 2
`define ISR_ESR_OPC 0
`define ISR_ESR_DEFINED 8'hbd

// operation bit positions
`define ISR_OP_CV 0
`define ISR_OP_CC 1
`define ISR_OP_OFF 2
`define ISR_OP_WMEAS 3
`define ISR_OP_WTRAN 4

// questionable bit positions
`define ISR_QS_OVV 0
`define ISR_QS_OVC 1
`define ISR_QS_PWF 2
`define ISR_QS_PLIMP 3
`define ISR_QS_OVT 4
`define ISR_QS_PLIMN 5
`define ISR_QS_INHB 9
`define ISR_QS_UNREG 10
`define ISR_QS_CPROT 11
`define ISR_QS_DEFINED 16'h0e3f

// reset values and the queued completion byte
`define ISR_RST_OPERATION_SUMMARY_RISE 5'h1f
`define ISR_RST_QUESTIONABLE_SUMMARY_RISE 16'h0e3f
`define ISR_RST_ZERO8 8'h00
`define ISR_RST_ZERO16 16'h0000
`define ISR_RST_ESR 8'h80
`define ISR_ASCII_ONE 8'h31

// command codes
`define ISR_CMD_OPERATION_SUMMARY_ENAB_WR 5'h01
`define ISR_CMD_OPERATION_SUMMARY_FALL_WR 5'h02
`define ISR_CMD_OPERATION_SUMMARY_RISE_WR 5'h03
`define ISR_CMD_QUESTIONABLE_SUMMARY_ENAB_WR 5'h04
`define ISR_CMD_QUESTIONABLE_SUMMARY_FALL_WR 5'h05
`define ISR_CMD_QUESTIONABLE_SUMMARY_RISE_WR 5'h06
`define ISR_CMD_ESE_WR 5'h07
`define ISR_CMD_SRE_WR 5'h08
`define ISR_CMD_OPERATION_SUMMARY_EVT_RD 5'h09
`define ISR_CMD_OPERATION_SUMMARY_COND_RD 5'h0a
`define ISR_CMD_OPERATION_SUMMARY_ENAB_RD 5'h0b
`define ISR_CMD_OPERATION_SUMMARY_FALL_RD 5'h0c
`define ISR_CMD_OPERATION_SUMMARY_RISE_RD 5'h0d
`define ISR_CMD_QUESTIONABLE_SUMMARY_EVT_RD 5'h0e
`define ISR_CMD_QUESTIONABLE_SUMMARY_COND_RD 5'h0f
`define ISR_CMD_QUESTIONABLE_SUMMARY_ENAB_RD 5'h10
`define ISR_CMD_QUESTIONABLE_SUMMARY_FALL_RD 5'h11
`define ISR_CMD_QUESTIONABLE_SUMMARY_RISE_RD 5'h12
`define ISR_CMD_ESE_RD 5'h13
`define ISR_CMD_ESR_RD 5'h14
`define ISR_CMD_SRE_RD 5'h15
`define ISR_CMD_STB_RD 5'h16
`define ISR_CMD_CLS 5'h17
`define ISR_CMD_OPC 5'h18
`define ISR_CMD_OPC_QRY 5'h19
`define ISR_CMD_WAI 5'h1a
`define ISR_CMD_POLL 5'h1b

`endif

// ---- logic/isr_status_core.v ----
// status byte, event groups, service request and completion tracking
`timescale 1ns/1ns
`include "isr_defs.vh"

module isr_status_core
#(
	parameter OPERATION_SUMMARY_W = 5,
	parameter QUESTIONABLE_SUMMARY_W = 16
)
(
	input wire i_clock,
	input wire i_rst,
	// command port from the parser
	input wire i_cmd_valid,
	input wire [4:0] i_cmd_code,
	input wire [15:0] i_cmd_data,
	input wire i_cls_after_terminator,
	input wire i_device_clear,
	output wire o_cmd_ready,
	output reg o_rsp_valid,
	output reg [15:0] o_rsp_data,
	// live conditions, asynchronous to this clock
	input wire [OPERATION_SUMMARY_W-1:0] i_operation_summary_condition,
	input wire [QUESTIONABLE_SUMMARY_W-1:0] i_questionable_summary_condition,
	// standard event pulses from the parser
	input wire i_command_error,
	input wire i_execution_error,
	input wire i_device_dependent_error,
	input wire i_query_error,
	// completion and queue state
	input wire i_ops_pending,
	input wire i_outq_not_empty,
	input wire i_errq_not_empty,
	output reg o_outq_push,
	output reg [7:0] o_outq_byte,
	output reg o_outq_flush,
	output reg o_errq_flush,
	output wire o_srq
);

	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_WAIT = 2'b10;

	// edge filter shared by both condition groups
	function [15:0] isr_filter;
		input [15:0] prev;
		input [15:0] now;
		input [15:0] fall;
		input [15:0] rise;
		begin
			isr_filter = (prev & ~now & fall) | (~prev & now & rise);
		end
	endfunction

	// synchronisers for the live conditions
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_sync1;
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_sync2;
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_prev;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_sync1;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_sync2;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_prev;

	reg [OPERATION_SUMMARY_W-1:0] operation_summary_enable;
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_falling_filter;
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_rising_filter;
	reg [OPERATION_SUMMARY_W-1:0] operation_summary_event;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_mask;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_falling_filter;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_rising_filter;
	reg [QUESTIONABLE_SUMMARY_W-1:0] questionable_event_latch;
	reg [7:0] standard_event_mask;
	reg [7:0] standard_event_latch;
	reg [7:0] service_request_mask;
	reg request_for_service;
	reg master_summary_prev;
	reg opc_armed;
	reg opc_query_armed;
	reg [1:0] state;

	wire [QUESTIONABLE_SUMMARY_W-1:0] questionable_live_condition;
	wire [OPERATION_SUMMARY_W-1:0] operation_summary_trig;
	wire [QUESTIONABLE_SUMMARY_W-1:0] questionable_summary_trig;
	wire [15:0] operation_summary_trig_w;
	wire [15:0] questionable_summary_trig_w;
	wire operation_summary;
	wire questionable_summary;
	wire event_summary;
	wire message_available;
	wire master_summary;
	wire [7:0] status_summary_byte;
	wire cmd_take;
	wire do_cls;
	wire rd_operation_summary_evt;
	wire rd_questionable_summary_evt;
	wire rd_esr;
	wire do_poll;
	wire [7:0] std_trig;
	wire opc_done;
	wire opc_query_done;

	assign questionable_live_condition = questionable_summary_sync2; // RULE6

	// pending-work tracking never stalls the port, only wait does
	assign o_cmd_ready = (state == ST_RUN) | (i_cmd_code == `ISR_CMD_POLL); // RULE15 RULE22
	assign cmd_take = i_cmd_valid & o_cmd_ready;
	assign do_cls = cmd_take & (i_cmd_code == `ISR_CMD_CLS);
	assign rd_operation_summary_evt = cmd_take & (i_cmd_code == `ISR_CMD_OPERATION_SUMMARY_EVT_RD);
	assign rd_questionable_summary_evt = cmd_take & (i_cmd_code == `ISR_CMD_QUESTIONABLE_SUMMARY_EVT_RD);
	assign rd_esr = cmd_take & (i_cmd_code == `ISR_CMD_ESR_RD);
	assign do_poll = cmd_take & (i_cmd_code == `ISR_CMD_POLL);

	assign operation_summary_trig_w = isr_filter({{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_prev}, {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_sync2},
		{{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_falling_filter}, {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_rising_filter}); // RULE2 RULE3
	assign operation_summary_trig = operation_summary_trig_w[OPERATION_SUMMARY_W-1:0];
	assign questionable_summary_trig_w = isr_filter(questionable_summary_prev, questionable_summary_sync2, questionable_falling_filter,
		questionable_rising_filter); // RULE8
	assign questionable_summary_trig = questionable_summary_trig_w[QUESTIONABLE_SUMMARY_W-1:0];

	assign opc_done = opc_armed & ~i_ops_pending; // RULE14
	assign opc_query_done = opc_query_armed & ~i_ops_pending; // RULE16

	assign std_trig = {1'b0, 1'b0, i_command_error, i_execution_error, i_device_dependent_error,
		i_query_error, 1'b0, opc_done}; // RULE12

	assign operation_summary = |(operation_summary_event & operation_summary_enable); // RULE1
	assign questionable_summary = |(questionable_event_latch & questionable_summary_mask); // RULE7
	assign event_summary = |(standard_event_latch & standard_event_mask); // RULE11
	// level follows the queue, so an emptied queue drops it at once
	assign message_available = i_outq_not_empty; // RULE20 RULE25

	assign status_summary_byte = {operation_summary, 1'b0, event_summary, message_available,
		questionable_summary, i_errq_not_empty, 2'b00}; // RULE21
	// bit 6 of the mask has no source bit and is ignored
	assign master_summary = |(status_summary_byte & service_request_mask); // RULE17
	assign o_srq = request_for_service; // RULE24

	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			operation_summary_sync1 <= {OPERATION_SUMMARY_W{1'b0}};
			operation_summary_sync2 <= {OPERATION_SUMMARY_W{1'b0}};
			operation_summary_prev <= {OPERATION_SUMMARY_W{1'b0}};
			questionable_summary_sync1 <= {QUESTIONABLE_SUMMARY_W{1'b0}};
			questionable_summary_sync2 <= {QUESTIONABLE_SUMMARY_W{1'b0}};
			questionable_summary_prev <= {QUESTIONABLE_SUMMARY_W{1'b0}};
		end
		else
		begin
			operation_summary_sync1 <= i_operation_summary_condition;
			operation_summary_sync2 <= operation_summary_sync1;
			operation_summary_prev <= operation_summary_sync2;
			questionable_summary_sync1 <= i_questionable_summary_condition;
			questionable_summary_sync2 <= questionable_summary_sync1;
			questionable_summary_prev <= questionable_summary_sync2;
		end
	end

	// mask and filter registers written by commands
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			operation_summary_enable <= {OPERATION_SUMMARY_W{1'b0}};
			operation_summary_falling_filter <= {OPERATION_SUMMARY_W{1'b0}};
			operation_summary_rising_filter <= `ISR_RST_OPERATION_SUMMARY_RISE; // RULE23
			questionable_summary_mask <= `ISR_RST_ZERO16;
			questionable_falling_filter <= `ISR_RST_ZERO16;
			questionable_rising_filter <= `ISR_RST_QUESTIONABLE_SUMMARY_RISE; // RULE5
			standard_event_mask <= `ISR_RST_ZERO8;
			service_request_mask <= `ISR_RST_ZERO8;
		end
		else if (cmd_take)
		begin
			case (i_cmd_code)
				`ISR_CMD_OPERATION_SUMMARY_ENAB_WR: operation_summary_enable <= i_cmd_data[OPERATION_SUMMARY_W-1:0];
				`ISR_CMD_OPERATION_SUMMARY_FALL_WR: operation_summary_falling_filter <= i_cmd_data[OPERATION_SUMMARY_W-1:0];
				`ISR_CMD_OPERATION_SUMMARY_RISE_WR: operation_summary_rising_filter <= i_cmd_data[OPERATION_SUMMARY_W-1:0];
				`ISR_CMD_QUESTIONABLE_SUMMARY_ENAB_WR: questionable_summary_mask <= i_cmd_data[QUESTIONABLE_SUMMARY_W-1:0];
				`ISR_CMD_QUESTIONABLE_SUMMARY_FALL_WR: questionable_falling_filter <= i_cmd_data[QUESTIONABLE_SUMMARY_W-1:0];
				`ISR_CMD_QUESTIONABLE_SUMMARY_RISE_WR: questionable_rising_filter <= i_cmd_data[QUESTIONABLE_SUMMARY_W-1:0];
				`ISR_CMD_ESE_WR: standard_event_mask <= i_cmd_data[7:0];
				`ISR_CMD_SRE_WR: service_request_mask <= i_cmd_data[7:0];
				default: ;
			endcase
		end
	end

	// event latches: a new event always beats a clearing read or clear-status
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			operation_summary_event <= {OPERATION_SUMMARY_W{1'b0}};
			questionable_event_latch <= {QUESTIONABLE_SUMMARY_W{1'b0}};
			standard_event_latch <= `ISR_RST_ESR;
		end
		else
		begin
			operation_summary_event <= ((rd_operation_summary_evt | do_cls) ? {OPERATION_SUMMARY_W{1'b0}} : operation_summary_event) | operation_summary_trig; // RULE26 RULE9
			questionable_event_latch <= ((rd_questionable_summary_evt | do_cls) ? {QUESTIONABLE_SUMMARY_W{1'b0}} : questionable_event_latch)
				| questionable_summary_trig; // RULE4 RULE26
			standard_event_latch <= ((rd_esr | do_cls) ? `ISR_RST_ZERO8 : standard_event_latch)
				| (std_trig & `ISR_ESR_DEFINED); // RULE13 RULE26
		end
	end

	// request for service latches on a new reason and holds until a poll or clear-status
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			request_for_service <= 1'b0;
			master_summary_prev <= 1'b0;
		end
		else
		begin
			master_summary_prev <= master_summary;
			if (master_summary & ~master_summary_prev)
				request_for_service <= 1'b1; // RULE24
			else if (do_poll | do_cls)
				request_for_service <= 1'b0; // RULE18 RULE9
		end
	end

	// completion tracking and the wait state
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			opc_armed <= 1'b0;
			opc_query_armed <= 1'b0;
			state <= ST_RUN;
		end
		else if (i_device_clear)
		begin
			opc_armed <= 1'b0;
			opc_query_armed <= 1'b0;
			state <= ST_RUN; // RULE22
		end
		else
		begin
			if (cmd_take & (i_cmd_code == `ISR_CMD_OPC))
				opc_armed <= 1'b1; // RULE14
			else if (opc_done)
				opc_armed <= 1'b0;
			if (cmd_take & (i_cmd_code == `ISR_CMD_OPC_QRY))
				opc_query_armed <= 1'b1; // RULE16
			else if (opc_query_done)
				opc_query_armed <= 1'b0;
			case (state)
				ST_RUN:
				begin
					if (cmd_take & (i_cmd_code == `ISR_CMD_WAI))
						state <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (~i_ops_pending)
						state <= ST_RUN; // RULE22
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	// queue side effects
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_outq_push <= 1'b0;
			o_outq_byte <= `ISR_RST_ZERO8;
			o_outq_flush <= 1'b0;
			o_errq_flush <= 1'b0;
		end
		else
		begin
			o_outq_push <= opc_query_done; // RULE16
			o_outq_byte <= `ISR_ASCII_ONE;
			o_outq_flush <= do_cls & i_cls_after_terminator; // RULE10
			o_errq_flush <= do_cls; // RULE9
		end
	end

	// responses, one cycle after the command is taken
	always @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_rsp_valid <= 1'b0;
			o_rsp_data <= `ISR_RST_ZERO16;
		end
		else
		begin
			o_rsp_valid <= 1'b0;
			o_rsp_data <= `ISR_RST_ZERO16;
			if (cmd_take)
			begin
				o_rsp_valid <= 1'b1;
				case (i_cmd_code)
					`ISR_CMD_OPERATION_SUMMARY_EVT_RD: o_rsp_data <= {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_event};
					`ISR_CMD_OPERATION_SUMMARY_COND_RD: o_rsp_data <= {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_sync2};
					`ISR_CMD_OPERATION_SUMMARY_ENAB_RD: o_rsp_data <= {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_enable};
					`ISR_CMD_OPERATION_SUMMARY_FALL_RD: o_rsp_data <= {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_falling_filter};
					`ISR_CMD_OPERATION_SUMMARY_RISE_RD: o_rsp_data <= {{(16-OPERATION_SUMMARY_W){1'b0}}, operation_summary_rising_filter};
					`ISR_CMD_QUESTIONABLE_SUMMARY_EVT_RD: o_rsp_data <= questionable_event_latch; // RULE4
					`ISR_CMD_QUESTIONABLE_SUMMARY_COND_RD: o_rsp_data <= questionable_live_condition; // RULE6
					`ISR_CMD_QUESTIONABLE_SUMMARY_ENAB_RD: o_rsp_data <= questionable_summary_mask;
					`ISR_CMD_QUESTIONABLE_SUMMARY_FALL_RD: o_rsp_data <= questionable_falling_filter;
					`ISR_CMD_QUESTIONABLE_SUMMARY_RISE_RD: o_rsp_data <= questionable_rising_filter;
					`ISR_CMD_ESE_RD: o_rsp_data <= {8'h00, standard_event_mask}; // RULE11
					`ISR_CMD_ESR_RD: o_rsp_data <= {8'h00, standard_event_latch}; // RULE13
					`ISR_CMD_SRE_RD: o_rsp_data <= {8'h00, service_request_mask};
					`ISR_CMD_STB_RD: o_rsp_data <= {8'h00, status_summary_byte | {1'b0, master_summary, 6'h00}}; // RULE19
					`ISR_CMD_POLL: o_rsp_data <= {8'h00, status_summary_byte | {1'b0, request_for_service, 6'h00}}; // RULE18
					default: o_rsp_valid <= 1'b0;
				endcase
			end
		end
	end

endmodule // isr_status_core

// ---- bench/isr_status_core_asserts.sv ----
// port-level concurrent checks for the status core
`timescale 1ns/1ns
`include "isr_defs.vh"
module isr_status_chk
(
	input wire i_clock,
	input wire i_rst,
	input wire i_cmd_valid,
	input wire [4:0] i_cmd_code,
	input wire i_cls_after_terminator,
	input wire i_device_clear,
	input wire o_cmd_ready,
	input wire o_rsp_valid,
	input wire [15:0] o_rsp_data,
	input wire i_ops_pending,
	input wire i_outq_not_empty,
	input wire i_errq_not_empty,
	input wire o_outq_push,
	input wire [7:0] o_outq_byte,
	input wire o_errq_flush,
	input wire o_outq_flush,
	input wire o_srq
);
	wire take = i_cmd_valid && o_cmd_ready;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	property p_rsp;
		take && ((i_cmd_code >= 5'h09 && i_cmd_code <= 5'h16) || i_cmd_code == `ISR_CMD_POLL) |=> o_rsp_valid;
	endproperty
	a_rsp: assert property (p_rsp) else $error("read got no response");
	property p_stb_bits;
		take && i_cmd_code == `ISR_CMD_STB_RD |=> o_rsp_data[4] == $past(i_outq_not_empty) && o_rsp_data[2] == $past(i_errq_not_empty);
	endproperty
	a_stb_bits: assert property (p_stb_bits) else $error("status byte queue bits wrong");
	property p_poll;
		take && i_cmd_code == `ISR_CMD_POLL |=> o_rsp_valid && o_rsp_data[6] == $past(o_srq);
	endproperty
	a_poll: assert property (p_poll) else $error("poll bit 6 not the request latch");
	property p_esr_unused;
		take && i_cmd_code == `ISR_CMD_ESR_RD |=> o_rsp_data[15:8] == 8'h00 && !o_rsp_data[6] && !o_rsp_data[1];
	endproperty
	a_esr_unused: assert property (p_esr_unused) else $error("unused event bits set");
	property p_cls;
		take && i_cmd_code == `ISR_CMD_CLS |=> o_errq_flush && (o_outq_flush == $past(i_cls_after_terminator));
	endproperty
	a_cls: assert property (p_cls) else $error("clear-status flushes wrong");
	property p_push_byte;
		o_outq_push |-> o_outq_byte == `ISR_ASCII_ONE;
	endproperty
	a_push_byte: assert property (p_push_byte) else $error("queued byte not ascii one");
	property p_wait;
		(take && i_cmd_code == `ISR_CMD_WAI && i_ops_pending && !i_device_clear) ##1
		(i_ops_pending && !i_device_clear && i_cmd_code != `ISR_CMD_POLL) |-> !o_cmd_ready;
	endproperty
	a_wait: assert property (p_wait) else $error("command taken during wait");
	property p_poll_ready;
		i_cmd_code == `ISR_CMD_POLL |-> o_cmd_ready;
	endproperty
	a_poll_ready: assert property (p_poll_ready) else $error("poll refused");
	property p_quiet;
		!take |=> !o_rsp_valid && o_rsp_data == 16'h0000;
	endproperty
	a_quiet: assert property (p_quiet) else $error("response without command");
	property p_dev_clear;
		i_device_clear |=> o_cmd_ready;
	endproperty
	a_dev_clear: assert property (p_dev_clear) else $error("wait not aborted by device clear");
endmodule // isr_status_chk
bind isr_status_core isr_status_chk isr_status_chk_i (.i_clock, .i_rst, .i_cmd_valid, .i_cmd_code,
	.i_cls_after_terminator, .i_device_clear, .o_cmd_ready, .o_rsp_valid, .o_rsp_data, .i_ops_pending,
	.i_outq_not_empty, .i_errq_not_empty, .o_outq_push, .o_outq_byte, .o_errq_flush, .o_outq_flush, .o_srq);

// ---- bench/isr_queue_model.sv ----
// output and error queue model on the far side of the status core
`timescale 1ns/1ns
module isr_queue_model
(
	input wire i_clock,
	input wire i_rst,
	input wire i_push,
	input wire [7:0] i_byte,
	input wire i_flush,
	input wire i_err_set,
	input wire i_err_flush,
	output reg o_outq_not_empty,
	output reg o_errq_not_empty,
	output reg [7:0] o_last_byte
);
	integer cnt;
	always @(posedge i_clock)
	begin
		if (i_rst || i_flush)
			cnt = 0;
		else
			cnt = cnt + i_push;
		if (i_push)
			o_last_byte <= i_byte;
		o_outq_not_empty <= cnt != 0;
		o_errq_not_empty <= !(i_rst || i_err_flush) && (o_errq_not_empty || i_err_set);
	end
endmodule // isr_queue_model

// ---- bench/tb_isr_status_core.sv ----
// self-checking bench for the status core
`timescale 1ns/1ns
`include "isr_defs.vh"
module tb_isr_status_core;
	reg i_clock, i_rst, i_cmd_valid, i_cls_after_terminator, i_ops_pending, err_set, rv, i_device_clear;
	reg [4:0] i_cmd_code, i_operation_summary_condition, wc, oc, ec;
	reg [15:0] i_cmd_data, i_questionable_summary_condition, rsp;
	reg [3:0] pulses;
	wire o_cmd_ready, o_rsp_valid, outq_ne, errq_ne, o_outq_push, o_outq_flush, o_errq_flush, o_srq;
	wire [15:0] o_rsp_data;
	wire [7:0] o_outq_byte, last_byte;
	reg [15:0] ev [0:1], en [0:1], fa [0:1], ri [0:1], cd [0:1], msk [0:1];
	reg [7:0] esr, ese, sre;
	reg [31:0] seed;
	integer mismatches, checks, g, k;
	isr_status_core isr_status_core_i
	(
		.i_clock(i_clock), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
		.i_cmd_data(i_cmd_data), .i_cls_after_terminator(i_cls_after_terminator),
		.i_device_clear(i_device_clear),
		.o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
		.i_operation_summary_condition(i_operation_summary_condition), .i_questionable_summary_condition(i_questionable_summary_condition),
		.i_command_error(pulses[3]), .i_execution_error(pulses[2]), .i_device_dependent_error(pulses[1]),
		.i_query_error(pulses[0]), .i_ops_pending(i_ops_pending), .i_outq_not_empty(outq_ne),
		.i_errq_not_empty(errq_ne), .o_outq_push(o_outq_push), .o_outq_byte(o_outq_byte),
		.o_outq_flush(o_outq_flush), .o_errq_flush(o_errq_flush), .o_srq(o_srq)
	);
	isr_queue_model isr_queue_model_i (.i_clock(i_clock), .i_rst(i_rst), .i_push(o_outq_push), .i_byte(o_outq_byte),
		.i_flush(o_outq_flush), .i_err_set(err_set), .i_err_flush(o_errq_flush), .o_outq_not_empty(outq_ne),
		.o_errq_not_empty(errq_ne), .o_last_byte(last_byte));
	function [15:0] rnd;
		input integer unused;
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = seed[15:0];
		end
	endfunction
	// status byte rebuilt from the model, master summary never feeds itself
	function [15:0] stb;
		input integer unused;
		reg [7:0] b;
		begin
			b = {|(ev[0] & en[0]), 1'b0, |(esr & ese), outq_ne, |(ev[1] & en[1]), errq_ne, 2'b00};
			b[6] = |(b & sre & 8'hbf);
			stb = {8'h00, b};
		end
	endfunction
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			checks = checks + 1;
			if (seen !== exp)
			begin
				mismatches = mismatches + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task cmd(input [4:0] c, input [15:0] d);
		integer n;
		reg r;
		begin
			@(posedge i_clock);
			i_cmd_valid <= 1'b1;
			i_cmd_code <= c;
			i_cmd_data <= d;
			n = 0;
			r = 1'b0;
			while (r !== 1'b1 && n < 300)
			begin
				@(negedge i_clock);
				r = o_cmd_ready;
				@(posedge i_clock);
				n = n + 1;
			end
			if (r !== 1'b1)
				mismatches = mismatches + 1;
			i_cmd_valid <= 1'b0;
			@(negedge i_clock);
			rv = o_rsp_valid;
			rsp = o_rsp_data;
		end
	endtask
	task q(input [4:0] c, input [15:0] e);
		begin
			cmd(c, 16'h0000);
			chk({15'h0000, rv}, 16'h0001);
			chk(rsp, e);
		end
	endtask
	task cond(input integer gr);
		reg [15:0] nw;
		begin
			nw = rnd(0) & msk[gr];
			ev[gr] = ev[gr] | (cd[gr] & ~nw & fa[gr]) | (~cd[gr] & nw & ri[gr]);
			cd[gr] = nw;
			@(posedge i_clock);
			if (gr == 1)
				i_questionable_summary_condition <= nw;
			else
				i_operation_summary_condition <= nw[4:0];
			// two sync flops plus the latching edge
			repeat (4) @(posedge i_clock);
		end
	endtask
	task evt(input [15:0] m);
		begin
			@(posedge i_clock);
			pulses <= m[3:0];
			esr = esr | {2'b00, m[3:0], 2'b00};
			@(posedge i_clock);
			pulses <= 4'h0;
		end
	endtask
	task summarize;
		begin
			if (mismatches == 0 && checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial
	begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	initial
	begin
		repeat (30000) @(posedge i_clock);
		mismatches = mismatches + 1;
		summarize;
	end
	initial
	begin
		{i_rst, i_cmd_valid, i_cls_after_terminator, i_ops_pending, err_set, i_device_clear} = 6'h20;
		{i_cmd_code, i_operation_summary_condition, i_cmd_data, i_questionable_summary_condition, pulses} = 0;
		seed = 32'hdd5a1da3;
		mismatches = 0;
		checks = 0;
		msk[0] = 16'h001f;
		msk[1] = `ISR_QS_DEFINED;
		for (g = 0; g < 2; g = g + 1)
			{ev[g], en[g], fa[g], cd[g]} = 0;
		ri[0] = {11'h000, `ISR_RST_OPERATION_SUMMARY_RISE};
		ri[1] = `ISR_RST_QUESTIONABLE_SUMMARY_RISE;
		{esr, ese, sre} = {`ISR_RST_ESR, 16'h0000};
		repeat (20) @(posedge i_clock);
		i_rst <= 1'b0;
		q(`ISR_CMD_OPERATION_SUMMARY_RISE_RD, ri[0]);
		q(`ISR_CMD_QUESTIONABLE_SUMMARY_RISE_RD, ri[1]);
		q(`ISR_CMD_ESR_RD, {8'h00, esr});
		esr = 8'h00;
		q(`ISR_CMD_ESR_RD, 16'h0000);
		for (g = 0; g < 2; g = g + 1)
			for (k = 0; k < 4; k = k + 1)
			begin
				wc = (g == 1) ? `ISR_CMD_QUESTIONABLE_SUMMARY_ENAB_WR : `ISR_CMD_OPERATION_SUMMARY_ENAB_WR;
				oc = (g == 1) ? 5'h0c : 5'h0a;
				ec = (g == 1) ? `ISR_CMD_QUESTIONABLE_SUMMARY_EVT_RD : `ISR_CMD_OPERATION_SUMMARY_EVT_RD;
				en[g] = rnd(0) & msk[g];
				fa[g] = rnd(0) & msk[g];
				ri[g] = rnd(0) & msk[g];
				cmd(wc, en[g]);
				cmd(wc + 5'h01, fa[g]);
				cmd(wc + 5'h02, ri[g]);
				q(wc + oc, en[g]);
				q(wc + oc + 5'h01, fa[g]);
				q(wc + oc + 5'h02, ri[g]);
				cond(g);
				cond(g);
				q(ec + 5'h01, cd[g]);
				q(`ISR_CMD_STB_RD, stb(0));
				q(ec, ev[g]);
				ev[g] = 16'h0000;
				q(ec, 16'h0000);
			end
		for (k = 0; k < 4; k = k + 1)
		begin
			{ese, sre} = rnd(0);
			sre = sre & 8'hbf;
			cmd(`ISR_CMD_ESE_WR, {8'h00, ese});
			cmd(`ISR_CMD_SRE_WR, {8'h00, sre});
			q(`ISR_CMD_ESE_RD, {8'h00, ese});
			q(`ISR_CMD_SRE_RD, {8'h00, sre});
			evt(rnd(0));
			q(`ISR_CMD_STB_RD, stb(0));
			q(`ISR_CMD_ESR_RD, {8'h00, esr});
			esr = 8'h00;
		end
		{sre, ese} = 16'h2020;
		cmd(`ISR_CMD_SRE_WR, {8'h00, sre});
		cmd(`ISR_CMD_ESE_WR, {8'h00, ese});
		cmd(`ISR_CMD_POLL, 16'h0000);
		evt(16'h0008);
		repeat (2) @(posedge i_clock);
		chk({15'h0000, o_srq}, 16'h0001);
		q(`ISR_CMD_POLL, stb(0));
		chk({15'h0000, o_srq}, 16'h0000);
		q(`ISR_CMD_POLL, stb(0) & 16'hffbf);
		q(`ISR_CMD_STB_RD, stb(0));
		sre = 8'h00;
		cmd(`ISR_CMD_SRE_WR, 16'h0000);
		q(`ISR_CMD_ESR_RD, {8'h00, esr});
		esr = 8'h00;
		evt(16'h0008);
		repeat (2) @(posedge i_clock);
		chk({15'h0000, o_srq}, 16'h0000);
		// pending work must not hold back later commands
		i_ops_pending <= 1'b1;
		cmd(`ISR_CMD_OPC, 16'h0000);
		cmd(`ISR_CMD_OPC_QRY, 16'h0000);
		q(`ISR_CMD_ESR_RD, {8'h00, esr});
		esr = 8'h00;
		@(posedge i_clock);
		i_ops_pending <= 1'b0;
		repeat (4) @(posedge i_clock);
		esr = 8'h01;
		chk({15'h0000, outq_ne}, 16'h0001);
		chk({8'h00, last_byte}, {8'h00, `ISR_ASCII_ONE});
		q(`ISR_CMD_STB_RD, stb(0));
		q(`ISR_CMD_ESR_RD, {8'h00, esr});
		esr = 8'h00;
		@(posedge i_clock);
		err_set <= 1'b1;
		evt(16'h0004);
		err_set <= 1'b0;
		cmd(`ISR_CMD_CLS, 16'h0000);
		{esr, ev[0], ev[1]} = 0;
		repeat (2) @(posedge i_clock);
		chk({14'h0000, errq_ne, outq_ne}, 16'h0001);
		q(`ISR_CMD_ESR_RD, 16'h0000);
		// event pulse lands on the very edge that takes the clearing read
		fork
			cmd(`ISR_CMD_ESR_RD, 16'h0000);
			evt(16'h0008);
		join
		chk(rsp, 16'h0000);
		q(`ISR_CMD_ESR_RD, {8'h00, esr});
		esr = 8'h00;
		@(posedge i_clock);
		i_cls_after_terminator <= 1'b1;
		cmd(`ISR_CMD_CLS, 16'h0000);
		repeat (2) @(posedge i_clock);
		chk({15'h0000, outq_ne}, 16'h0000);
		q(`ISR_CMD_STB_RD, stb(0));
		@(posedge i_clock);
		i_ops_pending <= 1'b1;
		cmd(`ISR_CMD_WAI, 16'h0000);
		@(posedge i_clock);
		i_cmd_valid <= 1'b1;
		i_cmd_code <= `ISR_CMD_STB_RD;
		repeat (5) @(negedge i_clock);
		chk({15'h0000, o_cmd_ready}, 16'h0000);
		@(posedge i_clock);
		i_ops_pending <= 1'b0;
		q(`ISR_CMD_STB_RD, stb(0));
		// second wait, left only through device clear
		@(posedge i_clock);
		i_ops_pending <= 1'b1;
		cmd(`ISR_CMD_WAI, 16'h0000);
		@(posedge i_clock);
		i_device_clear <= 1'b1;
		@(posedge i_clock);
		i_device_clear <= 1'b0;
		q(`ISR_CMD_STB_RD, stb(0));
		summarize;
	end
endmodule // tb_isr_status_core
